// ==== hw/wsf_defines.svh ====
`ifndef WSF_DEFINES_SVH
`define WSF_DEFINES_SVH

// cache coherency unit, one write-combining buffer spans exactly one
`define WSF_LINE_BYTES 64
`define WSF_LINE_OFS_W 6

// packed vector store granule and alignment
`define WSF_VEC_BYTES 16
`define WSF_VEC_OFS_W 4

// packed integer store granule
`define WSF_INT_BYTES 8
`define WSF_INT_OFS_W 3

// position of the select bit inside each mask byte
`define WSF_MASK_SEL_BIT 7

`endif

// ==== hw/wsf_pkg.sv ====
package wsf_pkg;

  typedef enum logic [3:0] {
    WSF_OP_STORE = 4'h0,
    WSF_OP_NT_INT = 4'h1,
    WSF_OP_NT_PS = 4'h2,
    WSF_OP_MASK_ST = 4'h3,
    WSF_OP_LOAD = 4'h4,
    WSF_OP_SFENCE = 4'h5,
    WSF_OP_LFENCE = 4'h6,
    WSF_OP_MFENCE = 4'h7,
    WSF_OP_CLFLUSH = 4'h8
  } wsf_op_t;

  typedef enum logic [2:0] {
    WSF_ATTR_UNCACHED = 3'h0,
    WSF_ATTR_WRITE_COMBINING_TYPE = 3'h1,
    WSF_ATTR_WRITE_THROUGH = 3'h4,
    WSF_ATTR_WRITE_PROTECT = 3'h5,
    WSF_ATTR_WRITE_BACK = 3'h6
  } wsf_attr_t;

  typedef enum logic [1:0] {
    WSF_IDLE,
    WSF_BUSY,
    WSF_FENCE
  } wsf_fsm_t;

endpackage

// ==== hw/wsf_unit.sv ====
`include "wsf_defines.svh"

module wsf_unit
  import wsf_pkg::*;
#(
  parameter int AW = 32,
  parameter int CW = 4
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic op_valid_i,
  input wsf_op_t op_i,
  input wire logic [AW-1:0] op_addr_i,
  input wire logic [AW-1:0] op_dst_idx_i,
  input wire logic [`WSF_VEC_BYTES*8-1:0] op_data_i,
  input wire logic [`WSF_VEC_BYTES*8-1:0] op_mask_i,
  input wsf_attr_t mem_type_i,
  input wire logic perm_fault_i,
  output logic op_ready_o,
  output logic fault_o,
  output logic fence_done_o,
  output logic mem_wr_valid_o,
  input wire logic mem_wr_ready_i,
  output logic [AW-`WSF_LINE_OFS_W-1:0] mem_wr_line_o,
  output logic [`WSF_LINE_BYTES*8-1:0] mem_wr_data_o,
  output logic [`WSF_LINE_BYTES-1:0] mem_wr_be_o,
  output logic mem_wr_alloc_o,
  input wire logic mem_wr_ack_i,
  output logic mem_rd_valid_o,
  input wire logic mem_rd_ready_i,
  output logic [AW-1:0] mem_rd_addr_o,
  output logic mem_rd_alloc_o,
  input wire logic mem_rd_ack_i,
  output logic cmo_valid_o,
  output logic [AW-`WSF_LINE_OFS_W-1:0] cmo_line_o,
  output logic cmo_bcast_o,
  input wire logic cmo_done_i
);

  localparam int LB = `WSF_LINE_BYTES;
  localparam int VB = `WSF_VEC_BYTES;
  localparam int IB = `WSF_INT_BYTES;
  localparam int LAW = AW - `WSF_LINE_OFS_W;

  typedef struct packed {
    wsf_fsm_t st;
    logic op_rdy;
    logic fault;
    logic fence_done;
    logic fence_st;
    logic fence_ld;
    logic cmb_vld;
    logic [LAW-1:0] cmb_line;
    logic [LB-1:0] cmb_be;
    logic [LB*8-1:0] cmb_data;
    logic wr_vld;
    logic [LAW-1:0] wr_line;
    logic [LB*8-1:0] wr_data;
    logic [LB-1:0] wr_be;
    logic wr_alloc;
    logic rd_vld;
    logic [AW-1:0] rd_addr;
    logic rd_alloc;
    logic cmo_vld;
    logic [LAW-1:0] cmo_line;
    logic cmo_bcast;
    logic [CW-1:0] st_cnt;
    logic [CW-1:0] ld_cnt;
  } wsf_state_t;

  wsf_state_t s_r;
  wsf_state_t s_nxt;

  logic take;
  logic is_nt;
  logic [AW-1:0] st_addr;
  logic [LAW-1:0] op_line;
  logic [1:0] vec_lane;
  logic [2:0] int_lane;
  logic [VB-1:0] byte_sel;
  logic [LB-1:0] st_be;
  logic [LB*8-1:0] st_data;
  logic hit;
  logic [LB-1:0] mrg_be;
  logic [LB*8-1:0] mrg_data;
  logic wr_fire;
  logic rd_fire;
  logic cmo_fire;

  assign take = op_valid_i & s_r.op_rdy & (s_r.st == WSF_IDLE);
  assign is_nt = (op_i == WSF_OP_NT_INT) || (op_i == WSF_OP_NT_PS) || (op_i == WSF_OP_MASK_ST);
  // masked store ignores the general address operand
  assign st_addr = (op_i == WSF_OP_MASK_ST) ? op_dst_idx_i : op_addr_i;
  assign op_line = st_addr[AW-1:`WSF_LINE_OFS_W];
  assign vec_lane = st_addr[`WSF_LINE_OFS_W-1:`WSF_VEC_OFS_W];
  assign int_lane = st_addr[`WSF_LINE_OFS_W-1:`WSF_INT_OFS_W];
  assign hit = s_r.cmb_vld && (s_r.cmb_line == op_line);
  assign wr_fire = s_r.wr_vld & mem_wr_ready_i;
  assign rd_fire = s_r.rd_vld & mem_rd_ready_i;
  assign cmo_fire = s_r.cmo_vld & cmo_done_i;

  // place the store into its byte lanes of the line
  always_comb begin
    byte_sel = '1;
    st_be = '0;
    st_data = '0;
    for (int j = 0; j < VB; j++) begin
      if (op_i == WSF_OP_MASK_ST) begin
        byte_sel[j] = op_mask_i[j*8+`WSF_MASK_SEL_BIT];
      end
    end
    for (int i = 0; i < LB; i++) begin
      if (op_i == WSF_OP_NT_INT) begin
        st_be[i] = ((i / IB) == int'(int_lane));
        st_data[i*8+:8] = op_data_i[(i%IB)*8+:8];
      end else begin
        st_be[i] = ((i / VB) == int'(vec_lane)) && byte_sel[i%VB];
        st_data[i*8+:8] = op_data_i[(i%VB)*8+:8];
      end
    end
  end

  // later bytes overwrite earlier ones inside the open line
  always_comb begin
    mrg_be = st_be;
    mrg_data = '0;
    if (hit) begin
      mrg_be = s_r.cmb_be | st_be;
    end
    for (int i = 0; i < LB; i++) begin
      if (st_be[i]) begin
        mrg_data[i*8+:8] = st_data[i*8+:8];
      end else if (hit) begin
        mrg_data[i*8+:8] = s_r.cmb_data[i*8+:8];
      end
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.fault = 1'b0;
    s_nxt.fence_done = 1'b0;
    if (wr_fire) begin
      s_nxt.wr_vld = 1'b0;
    end
    if (rd_fire) begin
      s_nxt.rd_vld = 1'b0;
    end
    if (cmo_fire) begin
      s_nxt.cmo_vld = 1'b0;
    end
    s_nxt.st_cnt = s_r.st_cnt + CW'(wr_fire) - CW'(mem_wr_ack_i);
    s_nxt.ld_cnt = s_r.ld_cnt + CW'(rd_fire) - CW'(mem_rd_ack_i);
    case (s_r.st)
      WSF_IDLE: begin
        if (take) begin
          s_nxt.fence_st = 1'b0;
          s_nxt.fence_ld = 1'b0;
          case (op_i)
            WSF_OP_NT_INT, WSF_OP_NT_PS, WSF_OP_MASK_ST: begin
              if ((op_i == WSF_OP_NT_PS) && (op_addr_i[`WSF_VEC_OFS_W-1:0] != '0)) begin
                s_nxt.fault = 1'b1;
              end else begin
                // a new line pushes the old one out and evicts any cached copy
                if (!hit) begin
                  if (s_r.cmb_vld) begin
                    s_nxt.wr_vld = 1'b1;
                    s_nxt.wr_line = s_r.cmb_line;
                    s_nxt.wr_data = s_r.cmb_data;
                    s_nxt.wr_be = s_r.cmb_be;
                    s_nxt.wr_alloc = 1'b0;
                  end
                  s_nxt.cmo_vld = 1'b1;
                  s_nxt.cmo_line = op_line;
                  s_nxt.cmo_bcast = 1'b0;
                end
                if ((&mrg_be) && !s_nxt.wr_vld) begin
                  // full line goes out as one bus write
                  s_nxt.wr_vld = 1'b1;
                  s_nxt.wr_line = op_line;
                  s_nxt.wr_data = mrg_data;
                  s_nxt.wr_be = mrg_be;
                  s_nxt.wr_alloc = 1'b0;
                  s_nxt.cmb_vld = 1'b0;
                  s_nxt.cmb_be = '0;
                end else begin
                  s_nxt.cmb_vld = 1'b1;
                  s_nxt.cmb_line = op_line;
                  s_nxt.cmb_be = mrg_be;
                  s_nxt.cmb_data = mrg_data;
                end
              end
            end
            WSF_OP_STORE: begin
              s_nxt.wr_vld = 1'b1;
              s_nxt.wr_line = op_line;
              s_nxt.wr_data = st_data;
              s_nxt.wr_be = st_be;
              s_nxt.wr_alloc = 1'b1;
            end
            WSF_OP_LOAD: begin
              s_nxt.rd_vld = 1'b1;
              s_nxt.rd_addr = op_addr_i;
              s_nxt.rd_alloc = (mem_type_i != WSF_ATTR_WRITE_COMBINING_TYPE);
            end
            WSF_OP_SFENCE, WSF_OP_LFENCE, WSF_OP_MFENCE: begin
              s_nxt.fence_st = (op_i != WSF_OP_LFENCE);
              s_nxt.fence_ld = (op_i != WSF_OP_SFENCE);
              if ((op_i != WSF_OP_LFENCE) && s_r.cmb_vld) begin
                s_nxt.wr_vld = 1'b1;
                s_nxt.wr_line = s_r.cmb_line;
                s_nxt.wr_data = s_r.cmb_data;
                s_nxt.wr_be = s_r.cmb_be;
                s_nxt.wr_alloc = 1'b0;
                s_nxt.cmb_vld = 1'b0;
                s_nxt.cmb_be = '0;
              end
            end
            WSF_OP_CLFLUSH: begin
              // same checks as a byte load; memory type plays no part
              if (perm_fault_i) begin
                s_nxt.fault = 1'b1;
              end else begin
                s_nxt.cmo_vld = 1'b1;
                s_nxt.cmo_line = op_line;
                s_nxt.cmo_bcast = 1'b1;
              end
            end
            default: begin
              s_nxt.fault = 1'b1;
            end
          endcase
          if ((op_i == WSF_OP_SFENCE) || (op_i == WSF_OP_LFENCE) || (op_i == WSF_OP_MFENCE)) begin
            s_nxt.st = WSF_FENCE;
          end else if (s_nxt.wr_vld || s_nxt.rd_vld || s_nxt.cmo_vld) begin
            s_nxt.st = WSF_BUSY;
          end
        end
      end
      WSF_BUSY: begin
        // busy ends only once the write, read and cache op requests have all been accepted
        if (!s_nxt.wr_vld && !s_nxt.rd_vld && !s_nxt.cmo_vld) begin
          s_nxt.st = WSF_IDLE;
        end
      end
      WSF_FENCE: begin
        // later accesses stay blocked by op_ready_o until the fence clears
        if ((!s_r.fence_st || (!s_nxt.wr_vld && (s_nxt.st_cnt == '0))) &&
            (!s_r.fence_ld || (!s_nxt.rd_vld && (s_nxt.ld_cnt == '0)))) begin
          s_nxt.st = WSF_IDLE;
          s_nxt.fence_done = 1'b1;
        end
      end
      default: begin
        s_nxt.st = WSF_IDLE;
      end
    endcase
    s_nxt.op_rdy = (s_nxt.st == WSF_IDLE);
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
      s_r.op_rdy <= 1'b1;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign op_ready_o = s_r.op_rdy;
  assign fault_o = s_r.fault;
  assign fence_done_o = s_r.fence_done;
  assign mem_wr_valid_o = s_r.wr_vld;
  assign mem_wr_line_o = s_r.wr_line;
  assign mem_wr_data_o = s_r.wr_data;
  assign mem_wr_be_o = s_r.wr_be;
  assign mem_wr_alloc_o = s_r.wr_alloc;
  assign mem_rd_valid_o = s_r.rd_vld;
  assign mem_rd_addr_o = s_r.rd_addr;
  assign mem_rd_alloc_o = s_r.rd_alloc;
  assign cmo_valid_o = s_r.cmo_vld;
  assign cmo_line_o = s_r.cmo_line;
  assign cmo_bcast_o = s_r.cmo_bcast;

  property p_ps_misalign;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      take && (op_i == WSF_OP_NT_PS) && (op_addr_i[3:0] != 4'h0) |=> fault_o && !mem_wr_valid_o && !cmo_valid_o;
  endproperty
  a_ps_misalign: assert property (p_ps_misalign) else $error("misaligned vector store did not fault");

  property p_nt_no_alloc;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      take && is_nt |=> !(mem_wr_valid_o && mem_wr_alloc_o);
  endproperty
  a_nt_no_alloc: assert property (p_nt_no_alloc) else $error("stream store write allocated");

  property p_mask_bytes;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      take && (op_i == WSF_OP_MASK_ST) && !s_r.cmb_vld && !(&st_be)
        |=> s_r.cmb_vld && (s_r.cmb_be == $past(st_be)) && (s_r.cmb_line == $past(op_dst_idx_i[AW-1:6]));
  endproperty
  a_mask_bytes: assert property (p_mask_bytes) else $error("masked store bytes or address wrong");

  property p_sfence_drained;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      fence_done_o && s_r.fence_st |-> (s_r.st_cnt == '0) && !s_r.cmb_vld && !mem_wr_valid_o;
  endproperty
  a_sfence_drained: assert property (p_sfence_drained) else $error("store fence done with stores pending");

  property p_lfence_drained;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      fence_done_o && s_r.fence_ld |-> (s_r.ld_cnt == '0) && !mem_rd_valid_o;
  endproperty
  a_lfence_drained: assert property (p_lfence_drained) else $error("load fence done with loads pending");

  property p_lfence_skips_stores;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      take && (op_i == WSF_OP_LFENCE) && (s_r.ld_cnt == '0) && !mem_rd_ack_i ##1 !mem_rd_ack_i |-> ##1 fence_done_o;
  endproperty
  a_lfence_skips_stores: assert property (p_lfence_skips_stores) else $error("load fence waited on stores");

  property p_flush_issue;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      take && (op_i == WSF_OP_CLFLUSH) && !perm_fault_i
        |=> cmo_valid_o && cmo_bcast_o && (cmo_line_o == $past(op_addr_i[AW-1:6])) && !fault_o;
  endproperty
  a_flush_issue: assert property (p_flush_issue) else $error("flush not broadcast for its line");

  property p_flush_fault;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      take && (op_i == WSF_OP_CLFLUSH) && perm_fault_i |=> fault_o && !cmo_valid_o;
  endproperty
  a_flush_fault: assert property (p_flush_fault) else $error("faulting flush was issued");

  property p_wc_read;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      take && (op_i == WSF_OP_LOAD) && (mem_type_i == WSF_ATTR_WRITE_COMBINING_TYPE) |=> mem_rd_valid_o && !mem_rd_alloc_o;
  endproperty
  a_wc_read: assert property (p_wc_read) else $error("write-combining read allocated");

  property p_wr_hold;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      mem_wr_valid_o && !mem_wr_ready_i |=> mem_wr_valid_o && $stable(mem_wr_line_o) && $stable(mem_wr_be_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write request dropped before ready");

  property p_cv_mfence;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      take && (op_i == WSF_OP_MFENCE) && s_r.cmb_vld ##[1:64] fence_done_o;
  endproperty
  c_cv_mfence: cover property (p_cv_mfence);

  property p_cv_line_evict;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      take && is_nt && s_r.cmb_vld && !hit;
  endproperty
  c_cv_line_evict: cover property (p_cv_line_evict);

  property p_cv_full_line;
    @(posedge core_clk_i iff ce_i) disable iff (sys_rst_i)
      take && is_nt && hit && (&mrg_be);
  endproperty
  c_cv_full_line: cover property (p_cv_full_line);

endmodule

// ==== sim/tb_wsf_unit.sv ====
module tb_wsf_unit
  import wsf_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [25:0] line; logic [63:0] be; logic [511:0] data; logic alloc;} wsf_wr_t;
  logic clk, rst, ce, ov, pf, slow, rdy, flt, fd, wv, wr, wal, wk, rv, rr, ral, rk, cv, cb, cd;
  wsf_op_t op;
  wsf_attr_t mt;
  logic [31:0] oa, od, ra;
  logic [127:0] odat, omask;
  logic [25:0] wl, cl;
  logic [511:0] wd;
  logic [63:0] wbe;
  int seed = 32'h5ca5e3b7;
  int err_total, n_compared, exp_flt, flt_seen, exp_fd, fd_seen, cyc;
  wsf_wr_t q_wr[$];
  wsf_wr_t w;
  logic [26:0] q_cmo[$];
  logic [32:0] q_rd[$];
  logic buf_v;
  logic [25:0] buf_line;
  logic [63:0] buf_be;
  logic [511:0] buf_data;
  wsf_attr_t attrs [5] = '{WSF_ATTR_UNCACHED, WSF_ATTR_WRITE_COMBINING_TYPE, WSF_ATTR_WRITE_THROUGH,
                           WSF_ATTR_WRITE_PROTECT, WSF_ATTR_WRITE_BACK};

  wsf_unit wsf_unit_inst (.core_clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .op_valid_i(ov), .op_i(op),
    .op_addr_i(oa), .op_dst_idx_i(od), .op_data_i(odat), .op_mask_i(omask), .mem_type_i(mt),
    .perm_fault_i(pf), .op_ready_o(rdy), .fault_o(flt), .fence_done_o(fd), .mem_wr_valid_o(wv),
    .mem_wr_ready_i(wr), .mem_wr_line_o(wl), .mem_wr_data_o(wd), .mem_wr_be_o(wbe), .mem_wr_alloc_o(wal),
    .mem_wr_ack_i(wk), .mem_rd_valid_o(rv), .mem_rd_ready_i(rr), .mem_rd_addr_o(ra), .mem_rd_alloc_o(ral),
    .mem_rd_ack_i(rk), .cmo_valid_o(cv), .cmo_line_o(cl), .cmo_bcast_o(cb), .cmo_done_i(cd));
  wsf_mem_model wsf_mem_model_inst (.core_clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .slow_i(slow),
    .wr_valid_i(wv), .wr_ready_o(wr), .wr_ack_o(wk), .rd_valid_i(rv), .rd_ready_o(rr), .rd_ack_o(rk),
    .cmo_valid_i(cv), .cmo_done_o(cd));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  function automatic logic [511:0] bmask(logic [63:0] be);
    for (int i = 0; i < 64; i++) bmask[i*8+:8] = {8{be[i]}};
  endfunction

  task automatic chk(string s, logic [602:0] e, logic [602:0] g);
    n_compared++;
    if (e !== g) begin
      err_total++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic chk_n(string s, int e, int g);
    chk(s, 603'(e), 603'(g));
  endtask

  task automatic flush_buf;
    if (buf_v) q_wr.push_back('{buf_line, buf_be, buf_data & bmask(buf_be), 1'b0});
    buf_v = 0;
    buf_be = 0;
  endtask

  task automatic merge(logic [31:0] a, logic [127:0] d, logic [15:0] en, int nb);
    int base;
    base = (a[5:0] / nb) * nb;
    if (buf_v && buf_line != a[31:6]) flush_buf;
    if (!buf_v) q_cmo.push_back({a[31:6], 1'b0});
    buf_v = 1;
    buf_line = a[31:6];
    for (int j = 0; j < nb; j++) if (en[j]) begin
      buf_data[(base+j)*8+:8] = d[j*8+:8];
      buf_be[base+j] = 1'b1;
    end
    if (&buf_be) flush_buf;
  endtask

  task automatic run(wsf_op_t o, logic [31:0] a, logic p = 0, wsf_attr_t t = WSF_ATTR_WRITE_BACK);
    logic [127:0] d, m;
    logic [15:0] en;
    int n;
    d = {$random(seed), $random(seed), $random(seed), $random(seed)};
    m = {$random(seed), $random(seed), $random(seed), $random(seed)};
    for (int j = 0; j < 16; j++) en[j] = m[8*j+7];
    case (o)
      WSF_OP_NT_PS: if (a[3:0] != 4'h0) exp_flt++; else merge(a, d, 16'hffff, 16);
      WSF_OP_NT_INT: merge(a, d, 16'h00ff, 8);
      WSF_OP_MASK_ST: merge(a, d, en, 16);
      WSF_OP_STORE: q_wr.push_back('{a[31:6], 64'hffff << (a[5:4]*16), ({384'h0, d} << (a[5:4]*128)), 1'b1});
      WSF_OP_LOAD: q_rd.push_back({a, t != WSF_ATTR_WRITE_COMBINING_TYPE});
      WSF_OP_SFENCE, WSF_OP_MFENCE: begin
        flush_buf;
        exp_fd++;
      end
      WSF_OP_LFENCE: exp_fd++;
      WSF_OP_CLFLUSH: if (p) exp_flt++; else q_cmo.push_back({a[31:6], 1'b1});
      default: exp_flt++;
    endcase
    @(posedge clk);
    ov <= 1;
    op <= o;
    // index register carries the masked store address, the plain address must not matter
    oa <= (o == WSF_OP_MASK_ST) ? ~a : a;
    od <= a;
    odat <= d;
    omask <= m;
    pf <= p;
    mt <= t;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(rdy === 1'b1 && ce === 1'b1) && n < 500);
    if (n >= 500) begin
      err_total++;
      $display("Error op take expected taken seen stuck");
    end
    ov <= 0;
  endtask

  task automatic fin_test(string s);
    int n;
    n = 0;
    while (!(rdy === 1'b1 && q_wr.size() + q_cmo.size() + q_rd.size() == 0) && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600) begin
      err_total++;
      $display("Error drain expected idle seen busy");
    end
    repeat (10) @(posedge clk);
    chk_n("fault count", exp_flt, flt_seen);
    chk_n("fence done count", exp_fd, fd_seen);
    chk_n("results left", 0, q_wr.size() + q_cmo.size() + q_rd.size());
    $display("test %s done", s);
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (!rst && ce) begin
      if (wv === 1'b1 && wr) begin
        if (q_wr.size() > 0) w = q_wr.pop_front(); else w = 'x;
        chk("mem write", w, {wl, wbe, wd & bmask(wbe), wal});
      end
      if (rv === 1'b1 && rr) chk("mem read", q_rd.size() > 0 ? q_rd.pop_front() : 'x, {ra, ral});
      if (cv === 1'b1 && cd) chk("cache op", q_cmo.size() > 0 ? q_cmo.pop_front() : 'x, {cl, cb});
      if (flt === 1'b1) flt_seen++;
      if (fd === 1'b1) fd_seen++;
    end
  end

  always @(posedge clk) begin
    ce <= ($random(seed) & 3) != 0;
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      complete_run;
    end
  end

  initial begin
    {rst, ov, pf, slow, buf_v} = 5'h10;
    {oa, od, odat, omask, buf_line, buf_be, buf_data} = '0;
    op = WSF_OP_STORE;
    mt = WSF_ATTR_WRITE_BACK;
    repeat (3) @(posedge clk);
    rst <= 0;
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      run(WSF_OP_NT_PS, 32'h1000);
      run(WSF_OP_NT_PS, 32'h1024);
      run(WSF_OP_NT_INT, 32'h1008);
      run(WSF_OP_NT_INT, 32'h100c);
      run(WSF_OP_MASK_ST, 32'h1030);
      run(WSF_OP_SFENCE, 32'h0);
      fin_test("stream merge");
      for (int i = 0; i < 4; i++) run(WSF_OP_NT_PS, 32'h2000 + i * 16);
      run(WSF_OP_NT_INT, 32'h3000);
      run(WSF_OP_NT_INT, 32'h3040);
      run(WSF_OP_LFENCE, 32'h0);
      run(WSF_OP_MFENCE, 32'h0);
      fin_test("line switch");
      run(WSF_OP_LOAD, 32'h4004, 0, WSF_ATTR_WRITE_COMBINING_TYPE);
      run(WSF_OP_LOAD, 32'h4008);
      run(WSF_OP_LFENCE, 32'h0);
      run(WSF_OP_STORE, 32'h4030);
      run(WSF_OP_MFENCE, 32'h0);
      fin_test("loads");
      run(WSF_OP_MFENCE, 32'h0);
      // masked store into an empty buffer opens a new line
      run(WSF_OP_MASK_ST, 32'h5010);
      run(WSF_OP_NT_INT, 32'h5000);
      for (int i = 0; i < 5; i++) run(WSF_OP_CLFLUSH, 32'h6000 + i * 65, 0, attrs[i]);
      run(WSF_OP_CLFLUSH, 32'h7000, 1);
      run(wsf_op_t'(4'hf), 32'h0);
      run(WSF_OP_MFENCE, 32'h0);
      fin_test("flush");
    end
    complete_run;
  end
endmodule

// ==== sim/wsf_mem_model.sv ====
module wsf_mem_model (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic slow_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic wr_ack_o,
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  output logic rd_ack_o,
  input wire logic cmo_valid_i,
  output logic cmo_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'h1f2e3d4c;
  int wp;
  int rp;
  logic [31:0] g;
  // outputs hold while ce_i is low, so the frozen block sees each pulse once
  always @(posedge core_clk_i) begin
    g = $random(seed);
    if (sys_rst_i) begin
      {wr_ready_o, wr_ack_o, rd_ready_o, rd_ack_o, cmo_done_o} <= 5'h00;
      wp = 0;
      rp = 0;
    end else if (ce_i) begin
      if (wr_valid_i && wr_ready_o) wp++;
      if (rd_valid_i && rd_ready_o) rp++;
      wr_ready_o <= wr_valid_i && !wr_ready_o && (!slow_i || g[1:0] == 2'h0);
      rd_ready_o <= rd_valid_i && !rd_ready_o && (!slow_i || g[3]);
      cmo_done_o <= cmo_valid_i && !cmo_done_o && (!slow_i || g[5:4] == 2'h0);
      // visibility lags acceptance, never more acks than accepted requests
      wr_ack_o <= wp > 0 && (!slow_i || g[6]);
      rd_ack_o <= rp > 0 && (!slow_i || g[7]);
      if (wp > 0 && (!slow_i || g[6])) wp--;
      if (rp > 0 && (!slow_i || g[7])) rp--;
    end
  end
endmodule
